// File: include/rtbu_pkg.sv
// Purpose: shared constants and types of the register-transfer and bit-string unit
// Assumes: 32-bit APB register window, 64-bit general data, 82-bit floating format
// Notes: register offsets, command and status field positions and register-format encodings used by the logic live here
package rtbu_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SRC_LO = 8'h04;
    localparam logic [7:0] ADDR_SRC_HI = 8'h08;
    localparam logic [7:0] ADDR_RES_LO = 8'h0C;
    localparam logic [7:0] ADDR_RES_HI = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_PRED_LO = 8'h18;
    localparam logic [7:0] ADDR_PRED_HI = 8'h1C;
    // Command word field layout
    localparam int OP_LSB = 0;
    localparam int OP_W = 5;
    localparam int IDX_LSB = 5;
    localparam int IDX_W = 5;
    localparam int HINT_LSB = 10;
    localparam int HINT_W = 2;
    localparam int MASK_LSB = 12;
    localparam int MASK_W = 16;
    localparam int NAT_BIT = 28;
    localparam int FILE_LSB = 29;
    localparam int FILE_W = 3;
    // Status word layout
    localparam int ST_NAT_BIT = 0;
    localparam int ST_ILL_BIT = 1;
    localparam int ST_UM_LSB = 2;
    // Predicate file
    localparam int PR_N = 64;
    localparam int PR_STATIC_TOP = 15;
    localparam int PR_ROT_LSB = 16;
    // Floating register format
    localparam int FR_W = 82;
    localparam int EXP_W = 17;
    localparam int SIG_W = 64;
    localparam logic [16:0] EXP_INT = 17'h1003E;
    localparam logic [16:0] EXP_NATVAL = 17'h1FFFE;
    localparam logic [16:0] EXP_SPECIAL = 17'h1FFFF;
    localparam logic [16:0] D_REBIAS = 17'h0FC00;
    localparam logic [16:0] S_REBIAS = 17'h0FF80;
    localparam logic [10:0] D_EMAX = 11'h7FF;
    localparam logic [63:0] SIG_ONE = 64'h8000000000000000;
    localparam logic [6:0] CLZ_ALL_ZERO = 7'h40;
    // Operations
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_MOV_TO = 5'h01, OP_MOV_FROM = 5'h02,
        OP_SET_SIG = 5'h03, OP_SET_EXP = 5'h04, OP_SET_S = 5'h05, OP_SET_D = 5'h06,
        OP_GET_SIG = 5'h07, OP_GET_EXP = 5'h08, OP_GET_S = 5'h09, OP_GET_D = 5'h0A,
        OP_SUM = 5'h0B, OP_RUM = 5'h0C, OP_BITS = 5'h0D,
        OP_LOAD = 5'h0E, OP_STORE = 5'h0F
    } rtbu_op_t;
    // Register file selected by the operand of a shared move
    typedef enum logic [2:0] {
        FILE_GR = 3'h0, FILE_FR = 3'h1, FILE_BR = 3'h2, FILE_PR = 3'h3,
        FILE_UM = 3'h4, FILE_PMD = 3'h5, FILE_CPUID = 3'h6, FILE_IP = 3'h7
    } rtbu_file_t;
    // Bit-string kinds, carried in the index field of OP_BITS
    typedef enum logic [2:0] {
        BK_CZX1_L = 3'h0, BK_CZX1_R = 3'h1, BK_CZX2_L = 3'h2, BK_CZX2_R = 3'h3,
        BK_POPCNT = 3'h4, BK_CLZ = 3'h5
    } rtbu_bits_kind_t;
endpackage

// File: include/rtbu_bits_if.sv
// Purpose: carrier between the unit and its bit-string engine
// Assumes: purely combinational engine
// Notes: the user side registers the answer
`timescale 1ns/1ps
interface rtbu_bits_if;
    logic [63:0] src;
    rtbu_pkg::rtbu_bits_kind_t kind;
    logic [63:0] result;
    modport calc (input src, input kind, output result);
    modport user (output src, output kind, input result);
endinterface

// File: design/rtbu_bits.sv
// Purpose: zero-element index, population count and leading-zero count
// Assumes: one operation per cycle, no state
// Notes: deep but simple loops; timing closes at the core clock by retiming downstream
`timescale 1ns/1ps
module rtbu_bits (
    // Operand and answer
    rtbu_bits_if.calc bif
);
    import rtbu_pkg::*;

    // Index of first zero element, or element count when none
    function automatic logic [63:0] zero_index(input logic [63:0] v, input logic half,
                                               input logic left);
        int n;
        int p;
        logic z;
        logic [63:0] r;
        n = half ? 4 : 8;
        r = half ? 64'h4 : 64'h8;
        // Walk backwards so that the lowest index wins
        for (int k = 7; k >= 0; k--) begin
            p = left ? (n - 1 - k) : k;
            z = half ? (v[16*(p & 3) +: 16] == 16'h0000) : (v[8*(p & 7) +: 8] == 8'h00);
            if (k < n && z) begin
                r = 64'(k);
            end
        end
        return r;
    endfunction

    // Count of set bits
    function automatic logic [63:0] ones(input logic [63:0] v);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 64; i++) begin
            c = c + {6'h00, v[i]};
        end
        return {57'h0, c};
    endfunction

    // Leading zeros from the top bit; an all-zero word yields 64
    function automatic logic [63:0] lead_zeros(input logic [63:0] v);
        logic [6:0] c;
        c = CLZ_ALL_ZERO;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) begin
                c = 7'(63 - i);
            end
        end
        return {57'h0, c};
    endfunction

    // Operation select
    always_comb begin
        unique case (bif.kind)
            BK_CZX1_L: bif.result = zero_index(bif.src, 1'b0, 1'b1);
            BK_CZX1_R: bif.result = zero_index(bif.src, 1'b0, 1'b0);
            BK_CZX2_L: bif.result = zero_index(bif.src, 1'b1, 1'b1);
            BK_CZX2_R: bif.result = zero_index(bif.src, 1'b1, 1'b0);
            BK_POPCNT: bif.result = ones(bif.src);
            BK_CLZ: bif.result = lead_zeros(bif.src);
            default: bif.result = 64'h0;
        endcase
    end
endmodule

// File: design/rtbu_top.sv
// Purpose: register-file transfer and bit-string datapath behind an APB window
// Assumes: writing the command word issues one operation; operand staged before
// Notes: zero-wait APB while ce is high; all state freezes while ce is low
`timescale 1ns/1ps
module rtbu_top #(
    parameter int NUM_BR = 8,
    parameter int NUM_FR = 4,
    parameter int UM_W = 6,
    parameter int CPUID_N = 5,
    parameter logic [63:0] CPUID_SEED = 64'h000000005A5A0000 // Value is arbitrary
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Monitor data and system inputs
    output logic [rtbu_pkg::IDX_W-1:0] pmd_sel,
    input wire logic [63:0] pmd_rdata,
    input wire logic pmd_user_en,
    input wire logic [63:0] cur_ip,
    // Branch predictor hint
    output logic bp_hint_valid,
    output logic [rtbu_pkg::HINT_W-1:0] bp_hint,
    output logic [63:0] bp_target,
    // User mask out to the status register
    output logic [UM_W-1:0] psr_um
);
    import rtbu_pkg::*;

    logic [63:0] src_reg;
    logic [63:0] res_reg;
    logic res_nat_reg;
    logic ill_reg;
    logic [63:0] pred_reg;
    logic [UM_W-1:0] um_reg;
    logic [63:0] br_reg [NUM_BR];
    logic [FR_W-1:0] fr_reg [NUM_FR];
    logic bp_valid_reg;
    logic [HINT_W-1:0] bp_hint_reg;
    logic [63:0] bp_target_reg;
    logic [63:0] res_next;
    logic nat_next;
    logic ill_next;
    logic pr_we;
    logic um_we;
    logic [UM_W-1:0] um_next;
    logic br_we;
    logic fr_we;
    logic [FR_W-1:0] fr_next;
    logic [63:0] pr_mask;
    logic [FR_W-1:0] fr_sel;
    rtbu_bits_if bif ();

    // Bus handshake: stall the master while the unit is frozen
    logic access;
    logic wr_en;
    logic exec;
    logic mapped;
    assign pready = ce;
    assign access = psel & penable & ce;
    assign wr_en = access & pwrite;
    assign exec = wr_en & (paddr == ADDR_CTRL);
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_PRED_HI);
    assign pslverr = access & ~mapped;

    // Command fields taken straight from the write data
    rtbu_op_t op;
    rtbu_file_t fsel;
    logic [IDX_W-1:0] idx;
    logic [HINT_W-1:0] hint;
    logic [MASK_W-1:0] mask;
    logic src_nat;
    assign op = rtbu_op_t'(pwdata[OP_LSB +: OP_W]);
    assign fsel = rtbu_file_t'(pwdata[FILE_LSB +: FILE_W]);
    assign idx = pwdata[IDX_LSB +: IDX_W];
    assign hint = pwdata[HINT_LSB +: HINT_W];
    assign mask = pwdata[MASK_LSB +: MASK_W];
    assign src_nat = pwdata[NAT_BIT];
    assign pmd_sel = idx;

    // Mask bit 0 covers every rotating predicate; rotation base is never consulted
    assign pr_mask = {{(PR_N - PR_ROT_LSB){mask[0]}}, mask[PR_STATIC_TOP:1], 1'b0};

    // Bit-string engine
    assign bif.src = src_reg;
    assign bif.kind = rtbu_bits_kind_t'(idx[2:0]);
    rtbu_bits u_bits (
        .bif(bif.calc)
    );

    // Memory-format value into register format, rebiasing the exponent
    function automatic logic [FR_W-1:0] from_mem(input logic [63:0] v, input logic dbl);
        logic s;
        logic [16:0] e;
        logic [16:0] emax;
        logic [16:0] reb;
        logic [62:0] fr;
        s = dbl ? v[63] : v[31];
        e = dbl ? {6'h00, v[62:52]} : {9'h000, v[30:23]};
        emax = dbl ? {6'h00, D_EMAX} : {9'h000, D_EMAX[7:0]};
        reb = dbl ? D_REBIAS : S_REBIAS;
        fr = dbl ? {v[51:0], 11'h000} : {v[22:0], 40'h0};
        if (e == 17'h0 && fr == 63'h0) begin
            return {s, 17'h0, 64'h0};
        end else if (e == emax) begin
            return {s, EXP_SPECIAL, 1'b1, fr};
        end else if (e == 17'h0) begin
            return {s, 17'(reb + 17'h1), 1'b0, fr};
        end
        return {s, 17'(reb + e), 1'b1, fr};
    endfunction

    // Register-format value back to memory format
    function automatic logic [63:0] to_mem(input logic [FR_W-1:0] f, input logic dbl);
        logic s;
        logic [16:0] e;
        logic [16:0] em;
        logic [63:0] g;
        s = f[FR_W-1];
        e = f[SIG_W +: EXP_W];
        g = f[SIG_W-1:0];
        if (e == EXP_SPECIAL) begin
            em = {6'h00, D_EMAX};
        end else if (!g[63]) begin
            em = 17'h0;
        end else begin
            em = 17'(e - (dbl ? D_REBIAS : S_REBIAS));
        end
        return dbl ? {s, em[10:0], g[62:11]} : {32'h0, s, em[7:0], g[62:40]};
    endfunction

    // Identification words; contents are arbitrary
    function automatic logic [63:0] cpuid_word(input logic [IDX_W-1:0] i);
        return CPUID_SEED | {59'h0, i};
    endfunction

    assign fr_sel = (int'(idx) < NUM_FR) ? fr_reg[int'(idx) % NUM_FR] : '0;

    // Datapath: result, token and file write enables for the issued operation
    always_comb begin
        res_next = res_reg;
        nat_next = 1'b0;
        ill_next = 1'b0;
        pr_we = 1'b0;
        um_we = 1'b0;
        um_next = um_reg;
        br_we = 1'b0;
        fr_we = 1'b0;
        fr_next = fr_sel;
        unique case (op)
            OP_NOP: res_next = res_reg;
            OP_MOV_TO: begin
                unique case (fsel)
                    FILE_BR: begin
                        br_we = int'(idx) < NUM_BR;
                        ill_next = !br_we;
                    end
                    FILE_PR: pr_we = 1'b1;
                    FILE_UM: begin
                        um_we = 1'b1;
                        um_next = src_reg[UM_W-1:0];
                    end
                    default: ill_next = 1'b1;
                endcase
            end
            OP_MOV_FROM: begin
                unique case (fsel)
                    FILE_BR: begin
                        ill_next = int'(idx) >= NUM_BR;
                        res_next = ill_next ? 64'h0 : br_reg[int'(idx) % NUM_BR];
                    end
                    FILE_PR: res_next = pred_reg;
                    FILE_UM: res_next = {{(64 - UM_W){1'b0}}, um_reg};
                    FILE_PMD: res_next = pmd_user_en ? pmd_rdata : 64'h0;
                    FILE_CPUID: begin
                        ill_next = int'(idx) >= CPUID_N;
                        res_next = ill_next ? 64'h0 : cpuid_word(idx);
                    end
                    FILE_IP: res_next = cur_ip;
                    default: ill_next = 1'b1;
                endcase
            end
            OP_SET_SIG, OP_SET_EXP, OP_SET_S, OP_SET_D: begin
                fr_we = int'(idx) < NUM_FR;
                ill_next = !fr_we;
                if (src_nat) begin
                    fr_next = {1'b0, EXP_NATVAL, 64'h0};
                end else if (op == OP_SET_SIG) begin
                    fr_next = {1'b0, EXP_INT, src_reg};
                end else if (op == OP_SET_EXP) begin
                    fr_next = {src_reg[EXP_W], src_reg[EXP_W-1:0], SIG_ONE};
                end else begin
                    fr_next = from_mem(src_reg, op == OP_SET_D);
                end
            end
            OP_GET_SIG, OP_GET_EXP, OP_GET_S, OP_GET_D: begin
                ill_next = int'(idx) >= NUM_FR;
                if (fr_sel == {1'b0, EXP_NATVAL, 64'h0}) begin
                    nat_next = 1'b1;
                    res_next = 64'h0;
                end else if (op == OP_GET_SIG) begin
                    res_next = fr_sel[SIG_W-1:0];
                end else if (op == OP_GET_EXP) begin
                    res_next = {46'h0, fr_sel[FR_W-1:SIG_W]};
                end else begin
                    res_next = to_mem(fr_sel, op == OP_GET_D);
                end
            end
            OP_SUM, OP_RUM: begin
                um_we = 1'b1;
                um_next = (op == OP_SUM) ? (um_reg | src_reg[UM_W-1:0])
                                         : (um_reg & ~src_reg[UM_W-1:0]);
            end
            OP_BITS: res_next = bif.result;
            OP_LOAD, OP_STORE: begin
                // Only the two memory-capable files; others must stage through GR
                if (fsel == FILE_GR) begin
                    res_next = src_reg;
                end else if (fsel == FILE_FR && int'(idx) < NUM_FR) begin
                    fr_we = op == OP_LOAD;
                    fr_next = {1'b0, EXP_INT, src_reg};
                    res_next = (op == OP_STORE) ? fr_sel[SIG_W-1:0] : res_reg;
                end else begin
                    ill_next = 1'b1;
                end
            end
            default: ill_next = 1'b1;
        endcase
    end

    // Operand staging from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_reg <= 64'h0;
        end else if (ce && wr_en && paddr == ADDR_SRC_LO) begin
            src_reg[31:0] <= pwdata;
        end else if (ce && wr_en && paddr == ADDR_SRC_HI) begin
            src_reg[63:32] <= pwdata;
        end
    end

    // Result, token and illegal flag update on each issue
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_reg <= 64'h0;
            res_nat_reg <= 1'b0;
            ill_reg <= 1'b0;
        end else if (ce && exec) begin
            res_reg <= res_next;
            res_nat_reg <= nat_next;
            ill_reg <= ill_next;
        end
    end

    // Predicate file; bit 0 is pinned high whatever is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pred_reg <= 64'h1;
        end else if (ce && exec && pr_we) begin
            pred_reg <= ((pred_reg & ~pr_mask) | (src_reg & pr_mask)) | 64'h1;
        end
    end

    // User mask: only the unprivileged subset is held here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            um_reg <= '0;
        end else if (ce && exec && um_we) begin
            um_reg <= um_next;
        end
    end

    // Branch registers and the hint pulse toward the predictor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_BR; i++) begin
                br_reg[i] <= 64'h0;
            end
            bp_valid_reg <= 1'b0;
            bp_hint_reg <= '0;
            bp_target_reg <= 64'h0;
        end else if (ce) begin
            bp_valid_reg <= exec && br_we;
            if (exec && br_we) begin
                br_reg[int'(idx) % NUM_BR] <= src_reg;
                bp_hint_reg <= hint;
                bp_target_reg <= src_reg;
            end
        end
    end

    // Floating registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_FR; i++) begin
                fr_reg[i] <= '0;
            end
        end else if (ce && exec && fr_we) begin
            fr_reg[int'(idx) % NUM_FR] <= fr_next;
        end
    end

    // Read mux; unmapped reads return zero with an error
    always_comb begin
        unique case (paddr)
            ADDR_SRC_LO: prdata = src_reg[31:0];
            ADDR_SRC_HI: prdata = src_reg[63:32];
            ADDR_RES_LO: prdata = res_reg[31:0];
            ADDR_RES_HI: prdata = res_reg[63:32];
            ADDR_STATUS: prdata = 32'({um_reg, ill_reg, res_nat_reg});
            ADDR_PRED_LO: prdata = pred_reg[31:0];
            ADDR_PRED_HI: prdata = pred_reg[63:32];
            default: prdata = 32'h0;
        endcase
    end

    assign bp_hint_valid = bp_valid_reg;
    assign bp_hint = bp_hint_reg;
    assign bp_target = bp_target_reg;
    assign psr_um = um_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pred_zero_high: assert property (pred_reg[0])
        else $error("predicate zero not one");
    a_pred_mask_keep: assert property (exec && pr_we |=>
        (pred_reg & ~$past(pr_mask)) == ($past(pred_reg) & ~$past(pr_mask)))
        else $error("unmasked predicate changed");
    a_pred_mask_take: assert property (exec && pr_we |=>
        (pred_reg & $past(pr_mask)) == ($past(src_reg) & $past(pr_mask)))
        else $error("masked predicate not loaded");
    a_pred_read_all: assert property (exec && op == OP_MOV_FROM && fsel == FILE_PR
        |=> res_reg == $past(pred_reg))
        else $error("predicate read mismatch");
    a_pmd_gate_zero: assert property (exec && op == OP_MOV_FROM && fsel == FILE_PMD
        && !pmd_user_en |=> res_reg == 64'h0)
        else $error("monitor data leaked");
    a_ip_copy_value: assert property (exec && op == OP_MOV_FROM && fsel == FILE_IP
        |=> res_reg == $past(cur_ip))
        else $error("ip copy mismatch");
    a_clz_zero_src: assert property (exec && op == OP_BITS && bif.kind == BK_CLZ
        && src_reg == 64'h0 |=> res_reg == 64'h40)
        else $error("clz of zero not 64");
    a_hint_pass_on: assert property (exec && br_we |=> bp_hint_valid
        && bp_hint == $past(hint) ##1 !bp_hint_valid || $past(exec && br_we))
        else $error("branch hint not passed");
    a_mem_path_only: assert property (exec && (op == OP_LOAD || op == OP_STORE)
        && fsel != FILE_GR && fsel != FILE_FR |=> ill_reg)
        else $error("memory path to other file");
    a_setf_nat_tok: assert property (exec && fr_we && src_nat
        |=> fr_reg[$past(idx) % NUM_FR] == {1'b0, EXP_NATVAL, 64'h0})
        else $error("token not translated");

    c_pred_write: cover property (exec && pr_we);
    c_pmd_enabled: cover property (exec && fsel == FILE_PMD && pmd_user_en);
    c_bits_popcnt: cover property (exec && op == OP_BITS && bif.kind == BK_POPCNT);
    c_fr_round: cover property (exec && op == OP_SET_D ##[1:20] exec && op == OP_GET_D);
endmodule

// File: tb/rtbu_pmd_model.sv
// Purpose: monitor data source on the far side of the unit
// Assumes: answers at once to the selected index
// Notes: each index gives its own word, so a wrong select shows up
`timescale 1ns/1ps
module rtbu_pmd_model (
    // Select and answer
    input wire logic [4:0] pmd_sel,
    output logic [63:0] pmd_rdata
);
    // Pattern keyed on the index; the bench mirrors it
    assign pmd_rdata = {27'h4B2D1F0, pmd_sel, 27'h0123456, ~pmd_sel};
endmodule

// File: tb/test_regfile_transfer_bitstring_unit.sv
// Purpose: self-checking bench for the transfer and bit-string unit
// Assumes: zero-wait APB while ce is high; result readable after the command
// Notes: fixed-seed random sources with corner values mixed in
`timescale 1ns/1ps
module test_regfile_transfer_bitstring_unit;
    import rtbu_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, st;
    logic pready, pslverr, pmd_user_en = 0, bpv, err;
    logic [4:0] pmd_sel, x;
    logic [63:0] pmd_rdata, cur_ip = 64'h0, bpt, res, pe, s;
    logic [1:0] bph;
    logic [15:0] m;
    logic [5:0] um, psr_um;
    rtbu_op_t o;
    int error_cnt = 0, n_checks = 0, npulse = 0, np;
    always #2 pclk = ~pclk;
    rtbu_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pmd_sel(pmd_sel), .pmd_rdata(pmd_rdata),
        .pmd_user_en(pmd_user_en), .cur_ip(cur_ip), .bp_hint_valid(bpv), .bp_hint(bph),
        .bp_target(bpt), .psr_um(psr_um));
    rtbu_pmd_model pmd (.pmd_sel(pmd_sel), .pmd_rdata(pmd_rdata));
    // Count edges with the hint pulse high; one move must give exactly one
    always @(posedge pclk) if (bpv === 1'b1) npulse++;
    task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One transfer, then an idle cycle so psel is never driven twice at one edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait limit here; a hang is ended by the watchdog
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] cw(rtbu_op_t op, logic [4:0] i, logic [15:0] mk,
        rtbu_file_t f, logic n = 1'b0, logic [1:0] h = 2'h0);
        return {f, n, mk, h, i, op};
    endfunction
    task automatic ex(logic [63:0] v, logic [31:0] c);
        apb(1'b1, ADDR_SRC_LO, v[31:0], r);
        apb(1'b1, ADDR_SRC_HI, v[63:32], r);
        apb(1'b1, ADDR_CTRL, c, r);
        apb(1'b0, ADDR_RES_LO, 32'h0, res[31:0]);
        apb(1'b0, ADDR_RES_HI, 32'h0, res[63:32]);
        apb(1'b0, ADDR_STATUS, 32'h0, st);
    endtask
    // Expected bit-string answer; kinds follow the package encoding
    function automatic logic [63:0] bexp(int k, logic [63:0] v);
        int n, q, p2;
        n = (k < 2) ? 8 : 4;
        q = n;
        if (k == 4) return 64'($countones(v));
        if (k == 5) begin
            q = 64;
            for (int i = 0; i < 64; i++) if (v[i]) q = 63 - i;
            return 64'(q);
        end
        for (int p = 0; p < n; p++) begin
            p2 = k[0] ? p : n - 1 - p;
            if (((v >> (p * 64 / n)) & ((n == 8) ? 64'hFF : 64'hFFFF)) == 0 && p2 < q) q = p2;
        end
        return 64'(q);
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        results();
    end
    initial begin
        void'($urandom(13));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Zero source, all ones, one plain random, then random with a zeroed byte or halfword
        for (int i = 0; i < 24; i++) begin
            s = (i == 0) ? 64'h0 : (i == 1) ? 64'hFFFFFFFFFFFFFFFF : {$urandom, $urandom};
            if (i > 2 && i < 13) s[8 * ($urandom % 8) +: 8] = 8'h00;
            if (i >= 13) s[16 * ($urandom % 4) +: 16] = 16'h0000;
            for (int k = 0; k < 6; k++) begin
                ex(s, cw(OP_BITS, 5'(k), 16'h0000, FILE_GR));
                chk("bits", res, bexp(k, s));
            end
        end
        // Masked predicate loads; first pass tries to clear predicate zero
        pe = 64'h1;
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 64'h0 : {$urandom, $urandom};
            m = (i == 0) ? 16'hFFFF : 16'($urandom);
            ex(s, cw(OP_MOV_TO, 5'h00, m, FILE_PR));
            for (int k = 1; k < 16; k++) if (m[k]) pe[k] = s[k];
            if (m[0]) pe[63:16] = s[63:16];
            ex(64'h0, cw(OP_MOV_FROM, 5'h00, 16'h0000, FILE_PR));
            chk("pred", res, pe);
        end
        // User mask write, set and reset in turn
        um = 6'h00;
        for (int i = 0; i < 9; i++) begin
            s = {$urandom, $urandom};
            o = (i % 3 == 0) ? OP_MOV_TO : (i % 3 == 1) ? OP_SUM : OP_RUM;
            ex(s, cw(o, 5'h00, 16'h0000, FILE_UM));
            um = (o == OP_MOV_TO) ? s[5:0] : (o == OP_SUM) ? um | s[5:0] : um & ~s[5:0];
            chk("um", psr_um, um);
            ex(64'h0, cw(OP_MOV_FROM, 5'h00, 16'h0000, FILE_UM));
            chk("um_rd", res, um);
        end
        // Monitor read with permission off and on
        for (int i = 0; i < 4; i++) begin
            pmd_user_en <= i[0];
            x = 5'($urandom);
            ex(64'h0, cw(OP_MOV_FROM, x, 16'h0000, FILE_PMD));
            chk("pmd", res, i[0] ? {27'h4B2D1F0, x, 27'h0123456, ~x} : 64'h0);
        end
        // Identification words, one index past the end
        for (int i = 0; i < 6; i++) begin
            ex(64'h0, cw(OP_MOV_FROM, 5'(i), 16'h0000, FILE_CPUID));
            chk("cpuid", res, (i < 5) ? (64'h5A5A0000 | 64'(i)) : 64'h0);
            chk("ill", st[1], i >= 5);
        end
        cur_ip <= {$urandom, $urandom};
        ex(64'h0, cw(OP_MOV_FROM, 5'h00, 16'h0000, FILE_IP));
        chk("ip", res, cur_ip);
        // Branch moves with every hint value
        for (int i = 0; i < 4; i++) begin
            s = {$urandom, $urandom};
            np = npulse;
            ex(s, cw(OP_MOV_TO, 5'(i + 4), 16'h0000, FILE_BR, 1'b0, 2'(i)));
            chk("bp_cnt", 64'(npulse - np), 64'h1);
            chk("bp_hint", bph, 64'(i));
            chk("bp_tgt", bpt, s);
            ex(64'h0, cw(OP_MOV_FROM, 5'(i + 4), 16'h0000, FILE_BR));
            chk("br_rd", res, s);
        end
        // Both float move classes round-trip; single keeps only the low word
        for (int i = 0; i < 4; i++) begin
            ex(s, cw(rtbu_op_t'(OP_SET_SIG + i), 5'h01, 16'h0000, FILE_FR));
            ex(64'h0, cw(rtbu_op_t'(OP_GET_SIG + i), 5'h01, 16'h0000, FILE_FR));
            pe = (i == 1) ? {46'h0, s[17:0]} : (i == 2) ? {32'h0, s[31:0]} : s;
            chk("fr_move", res, pe);
        end
        // Deferred-exception token round trip
        ex(s, cw(OP_SET_D, 5'h02, 16'h0000, FILE_FR, 1'b1));
        ex(64'h0, cw(OP_GET_D, 5'h02, 16'h0000, FILE_FR));
        chk("nat_val", res, 64'h0);
        chk("nat_flag", st[0], 64'h1);
        // Memory path: general file passes, branch file refused
        ex(s, cw(OP_LOAD, 5'h00, 16'h0000, FILE_GR));
        chk("ld_gr", res, s);
        ex(s, cw(OP_LOAD, 5'h00, 16'h0000, FILE_BR));
        chk("ld_br", st[1], 64'h1);
        // Frozen unit holds the access phase until the enable returns
        ce <= 1'b0;
        fork
            begin
                repeat (6) @(posedge pclk);
                chk("stall", {pready, psel, penable}, 3'b011);
                ce <= 1'b1;
            end
        join_none
        apb(1'b1, ADDR_SRC_LO, 32'h0000A5A5, r);
        apb(1'b0, ADDR_SRC_LO, 32'h0, r);
        chk("frozen_wr", r, 32'h0000A5A5);
        apb(1'b0, 8'h20, 32'h0, r);
        chk("unmapped", {r, err}, {32'h0, 1'b1});
        results();
    end
endmodule
